//--- src/gpio_port_defs.svh
// Purpose: offsets, reset values and field positions of the pin ports
// Assumes: byte-wide register port, 16-bit addresses
// Notes: none
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH
`define OFS_LATCH 16'hffdc
`define OFS_INPUTS 16'hffdd
`define OFS_DIR 16'hffec
`define LATCH_RESET 8'hc0
`define DIR_RESET 8'hc0
`define LATCH_ONES_MASK 8'hc0
`define PIN_MASK 8'h1f
`define DIR_READ_VALUE 8'hff
`define FLASH_PIN 0
`endif

//--- src/gpio_port_pkg.sv
// Purpose: types shared by the pin port block
// Assumes: nothing
// Notes: power modes are one-hot
package gpio_port_pkg;
  typedef enum logic [6:0] {
    MODE_ACTIVE = 7'h01,
    MODE_SUBACTIVE = 7'h02,
    MODE_SLEEP = 7'h04,
    MODE_SUBSLEEP = 7'h08,
    MODE_WATCH = 7'h10,
    MODE_STANDBY = 7'h20,
    MODE_RESET = 7'h40
  } power_mode_t;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] rdata;
    logic [4:0] out;
    logic [4:0] oe_n;
    logic [4:0] b9_s1;
    logic [4:0] b9_s2;
    logic [7:0] ib_s1;
    logic [7:0] ib_s2;
  } port_state_t;
endpackage

//--- src/gpio_port.sv
// Purpose: five-pin bidirectional port and eight-pin input-only port
// Assumes: pins are asynchronous and pass two flip-flops
// Notes: oe_n low means the pin is driven
//
// Operation
// - latch is 8 bits, pins 4..0, reset c0
// - latch bits 7,6 read one, ignore writes
// - latch bit 5 reads zero, ignores writes
// - flash variant: latch bit 0 fixed zero
// - output pin reads back latched value
// - input pin reads sampled pin level, except flash variant pin 0 reads zero
// - direction one drives latch, zero floats
// - direction register reads all ones
// - direction resets to c0, all inputs
// - floats in reset/standby, holds in sleep/watch
// - eight input-only pins never drive
// - input register reads levels, ignores writes
// - converter-selected channel pin reads zero
// - input-only pins float in every mode
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "gpio_port_defs.svh"
module gpio_port #(
  parameter bit FLASH_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // operating mode and converter channel
  input wire gpio_port_pkg::power_mode_t power_mode,
  input wire logic [3:0] converter_channel_select,
  input wire logic converter_select_valid,
  // bidirectional pins
  input wire logic [4:0] bidir_port_pin_in,
  output logic [4:0] bidir_port_pin_out,
  output logic [4:0] bidir_port_pin_oe_n,
  // input-only pins
  input wire logic [7:0] input_only_pin
);
  import gpio_port_pkg::*;

  port_state_t s_q;
  port_state_t s_d;
  logic [7:0] latch_wmask;
  logic [7:0] b9_read;
  logic [7:0] ib_read;

  //////////////////////////////////////////////////////////////////////////
  // read values and next state
  always_comb begin
    latch_wmask = `PIN_MASK;
    if (FLASH_VARIANT) begin
      latch_wmask[`FLASH_PIN] = 1'b0;
    end
    b9_read = `LATCH_ONES_MASK |
      ({3'h0, (s_q.dir[4:0] & s_q.latch[4:0]) |
              (~s_q.dir[4:0] & s_q.b9_s2)} & latch_wmask);
    ib_read = s_q.ib_s2;
    if (converter_select_valid && !converter_channel_select[3]) begin
      ib_read[converter_channel_select[2:0]] = 1'b0;
    end
    s_d = s_q;
    s_d.b9_s1 = bidir_port_pin_in;
    s_d.b9_s2 = s_q.b9_s1;
    s_d.ib_s1 = input_only_pin;
    s_d.ib_s2 = s_q.ib_s1;
    s_d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `OFS_LATCH: s_d.rdata = b9_read;
        `OFS_INPUTS: s_d.rdata = ib_read;
        `OFS_DIR: s_d.rdata = `DIR_READ_VALUE;
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (wr && addr == `OFS_LATCH) begin
      s_d.latch = `LATCH_ONES_MASK | (wdata & latch_wmask);
    end
    if (wr && addr == `OFS_DIR) begin
      s_d.dir = `LATCH_ONES_MASK | (wdata & `PIN_MASK);
    end
    case (power_mode)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        s_d.out = s_q.latch[4:0];
        s_d.oe_n = ~s_q.dir[4:0];
      end
      MODE_SLEEP, MODE_WATCH, MODE_SUBSLEEP: begin
        s_d.out = s_q.out;
        s_d.oe_n = s_q.oe_n;
      end
      default: begin
        s_d.out = 5'h00;
        s_d.oe_n = 5'h1f;
      end
    endcase
    if (sys_rst) begin
      s_d = '0;
      s_d.latch = `LATCH_RESET;
      s_d.dir = `DIR_RESET;
      s_d.oe_n = 5'h1f;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdata = s_q.rdata;
  assign bidir_port_pin_out = s_q.out;
  assign bidir_port_pin_oe_n = s_q.oe_n;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_latch_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.latch[7:5] == 3'h6) else $error("latch fixed bits wrong");
  a_dir_reads_ones: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_DIR |=> rdata == 8'hff)
    else $error("direction read not ones");
  a_reset_values: assert property (@(posedge clk)
    sys_rst |=> s_q.latch == 8'hc0 && s_q.dir == 8'hc0 && s_q.oe_n == 5'h1f)
    else $error("reset values wrong");
  a_latch_read_bits: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_LATCH |=> rdata[7:5] == 3'h6)
    else $error("latch read fixed bits wrong");
  a_flash_bit_zero: assert property (@(posedge clk) disable iff (sys_rst)
    FLASH_VARIANT |-> s_q.latch[0] == 1'b0)
    else $error("flash bit writable");
  a_out_readback: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_LATCH |=>
    (rdata[4:0] & $past(s_q.dir[4:0])) ==
    ($past(s_q.latch[4:0]) & $past(s_q.dir[4:0])))
    else $error("output readback wrong");
  a_in_readback: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_LATCH |=>
    (rdata[4:0] & ~$past(s_q.dir[4:0]) & $past(latch_wmask[4:0])) ==
    ($past(s_q.b9_s2) & ~$past(s_q.dir[4:0]) & $past(latch_wmask[4:0])))
    else $error("input readback wrong");
  a_drive_active: assert property (@(posedge clk) disable iff (sys_rst)
    power_mode == MODE_ACTIVE |=> bidir_port_pin_oe_n == ~$past(s_q.dir[4:0]))
    else $error("active drive wrong");
  a_float_standby: assert property (@(posedge clk) disable iff (sys_rst)
    power_mode == MODE_STANDBY |=> bidir_port_pin_oe_n == 5'h1f)
    else $error("standby not floating");
  a_hold_sleep: assert property (@(posedge clk) disable iff (sys_rst)
    power_mode == MODE_SUBSLEEP |=> $stable(bidir_port_pin_oe_n))
    else $error("subsleep not holding");
  a_channel_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_INPUTS && converter_select_valid &&
    converter_channel_select == 4'h2 |=> rdata[2] == 1'b0)
    else $error("selected channel not zero");
  a_input_read: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr == `OFS_INPUTS && !converter_select_valid |=>
    rdata == $past(s_q.ib_s2)) else $error("input read wrong");
  c_latch_write: cover property (@(posedge clk)
    wr && addr == `OFS_LATCH ##1 rd && addr == `OFS_LATCH);
  c_dir_write: cover property (@(posedge clk) wr && addr == `OFS_DIR);
  c_sleep_hold: cover property (@(posedge clk)
    power_mode == MODE_ACTIVE ##1 power_mode == MODE_SLEEP);
endmodule

//--- verification/board_model.sv
// Purpose: board levels seen at the bidirectional pins
// Assumes: pull-ups hold floating pins high
// Notes: none
`timescale 1ns/1ns
module board_model (
  // pin side
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  // board side
  input wire logic [4:0] board_level,
  input wire logic board_drive,
  output logic [4:0] pin_level
);
  // board drives only pins that the port leaves floating
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_level[i] = !pin_oe_n[i] ? pin_out[i] :
        (board_drive ? board_level[i] : 1'b1);
    end
  end
endmodule

//--- verification/tb_gpio_port.sv
// Purpose: self-checking bench for the pin ports
// Assumes: board drives 0a onto floating pins
// Notes: none
`timescale 1ns/1ns
module tb_gpio_port;
  import gpio_port_pkg::*;
  logic clk = 0, sys_rst = 1, wr = 0, rd = 0, chv = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, ib = 8'ha5, rdata, rdata_f;
  logic [3:0] ch = 4'h0;
  logic [4:0] pin, pout, oe_n;
  power_mode_t mode = MODE_ACTIVE;
  int bad_count = 0, total_checks = 0;
  typedef struct {bit w; logic [15:0] a; logic [7:0] d;} row_t;
  row_t rows[13] = '{'{0,16'hffec,8'hff}, '{0,16'hffdc,8'hca},
    '{0,16'hffdd,8'ha5}, '{1,16'hffdd,8'h00}, '{0,16'hffdd,8'ha5},
    '{1,16'hffec,8'h1f}, '{0,16'hffec,8'hff}, '{0,16'hffdc,8'hc0},
    '{1,16'hffdc,8'hff}, '{0,16'hffdc,8'hdf}, '{1,16'hffdc,8'h15},
    '{0,16'hffdc,8'hd5}, '{0,16'h1234,8'h00}};
  gpio_port u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_mode(mode),
    .converter_channel_select(ch), .converter_select_valid(chv),
    .bidir_port_pin_in(pin), .bidir_port_pin_out(pout),
    .bidir_port_pin_oe_n(oe_n), .input_only_pin(ib));
  gpio_port #(.FLASH_VARIANT(1'b1)) u_dut_flash (.clk(clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata_f), .power_mode(mode), .converter_channel_select(ch),
    .converter_select_valid(chv), .bidir_port_pin_in(pin),
    .bidir_port_pin_out(), .bidir_port_pin_oe_n(),
    .input_only_pin(ib));
  board_model u_board (.pin_out(pout), .pin_oe_n(oe_n),
    .board_level(5'h0a), .board_drive(1'b1), .pin_level(pin));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_chk(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task automatic mode_chk(power_mode_t m, logic [4:0] o, logic [4:0] n);
    @(posedge clk);
    mode <= m;
    repeat (3) @(posedge clk);
    #1 chk({3'h0, pout}, {3'h0, o});
    chk({3'h0, oe_n}, {3'h0, n});
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    #1 chk({3'h0, oe_n}, 8'h1f);
    for (int i = 0; i < 13; i++) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      else rd_chk(rows[i].a, rows[i].d);
    end
    @(posedge clk);
    rd <= 1;
    addr <= 16'hffdc;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata_f, 8'hd4);
    mode_chk(MODE_ACTIVE, 5'h15, 5'h00);
    mode_chk(MODE_SLEEP, 5'h15, 5'h00);
    wr_reg(16'hffdc, 8'h0a);
    mode_chk(MODE_WATCH, 5'h15, 5'h00);
    mode_chk(MODE_SUBSLEEP, 5'h15, 5'h00);
    mode_chk(MODE_STANDBY, 5'h00, 5'h1f);
    mode_chk(MODE_SUBACTIVE, 5'h0a, 5'h00);
    chv <= 1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) ch <= i[3:0];
      rd_chk(16'hffdd, i < 8 ? 8'ha5 & ~(8'h01 << i) : 8'ha5);
    end
    @(posedge clk) sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    #1 chk({3'h0, oe_n}, 8'h1f);
    repeat (3) @(posedge clk);
    rd_chk(16'hffdc, 8'hca);
    tally_and_finish();
  end
  initial begin
    #(8 * 1000);
    bad_count++;
    tally_and_finish();
  end
endmodule
